// File: hamd_pkg.sv
// Package of address map constants for the host address map decoder
package hamd_pkg;

  typedef enum logic [3:0] {
    TGT_NONE,
    TGT_SYSMEM,
    TGT_PCI_MEM,
    TGT_ISA_MEM,
    TGT_ISA_IO,
    TGT_PCI_IO,
    TGT_CFG_DIRECT,
    TGT_CFG_ADDR,
    TGT_CFG_DATA,
    TGT_INTACK,
    TGT_FLASH_BIG,
    TGT_FLASH_BOOT,
    TGT_SYSIO
  } hamd_target_t;

  typedef enum logic {
    MAP_LEGACY,
    MAP_ALT
  } hamd_map_t;

  localparam logic [31:0] LEG_ISAIO_LO = 32'h8000_0000;
  localparam logic [31:0] LEG_CFGD_LO = 32'h8080_0000;
  localparam logic [31:0] LEG_PCIIO_LO = 32'h8100_0000;
  localparam logic [31:0] LEG_PCIIO_HI = 32'hBF7F_FFFF;
  localparam logic [31:0] LEG_INTACK_LO = 32'hBFFF_FFF0;
  localparam logic [31:0] LEG_PCIMEM_LO = 32'hC000_0000;
  localparam logic [31:0] LEG_PCIMEM_HI = 32'hFEFF_FFFF;
  localparam logic [31:0] FLASH_BIG_LO = 32'hFF00_0000;
  localparam logic [31:0] FLASH_BIG_HI = 32'hFF7F_FFFF;
  localparam logic [31:0] ALT_PCIMEM_LO = 32'h8000_0000;
  localparam logic [31:0] ALT_PCIMEM_HI = 32'hFCFF_FFFF;
  localparam logic [31:0] ALT_ISAMEM_LO = 32'hFD00_0000;
  localparam logic [31:0] ALT_ISAIO_LO = 32'hFE00_0000;
  localparam logic [31:0] ALT_PCIIO_LO = 32'hFE80_0000;
  localparam logic [31:0] ALT_CFGA_LO = 32'hFEC0_0000;
  localparam logic [31:0] ALT_CFGD_LO = 32'hFEE0_0000;
  localparam logic [31:0] ALT_INTACK_LO = 32'hFEF0_0000;
  localparam logic [31:0] HOLE_LO = 32'h000A_0000;
  localparam logic [31:0] HOLE_HI = 32'h000B_FFFF;
  localparam logic [31:0] CONTIG_CFGA = 32'h8000_0CF8;
  localparam logic [31:0] CONTIG_CFGD = 32'h8000_0CFC;
  localparam logic [31:0] DISC_CFGA = 32'h8006_7018;
  localparam logic [31:0] DISC_CFGD = 32'h8006_701C;
  localparam int IDSEL_FIRST_DEV = 11;
  localparam int IDSEL_FIRST_BIT = 11;
  localparam int IDSEL_COUNT = 8;
  localparam int MB_BIT = 20;
  localparam logic [31:0] ALIGN_256M_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] MEMTOP_RESET = 32'h7FFF_FFFF;
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_DWORD = 2'h3;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

endpackage

// File: hamd_pci_addr.sv
// PCI I/O address translation and configuration port detection
`timescale 1ns/1ps
module hamd_pci_addr (
  input wire logic [31:0] procAddr,
  input wire logic discontig,
  output logic [31:0] pciIoAddr,
  output logic cfgAddrHit,
  output logic cfgDataHit
);

  // Processor bit n (big-endian numbering) is little-endian bit 31-n
  always_comb
  begin
    if (discontig)
    begin
      pciIoAddr = {16'h0000, procAddr[22:12], procAddr[4:0]};
      cfgAddrHit = (procAddr[31:2] == hamd_pkg::DISC_CFGA[31:2]);
      cfgDataHit = (procAddr[31:2] == hamd_pkg::DISC_CFGD[31:2]);
    end
    else
    begin
      pciIoAddr = {1'b0, procAddr[30:0]};
      cfgAddrHit = (procAddr[31:2] == hamd_pkg::CONTIG_CFGA[31:2]);
      cfgDataHit = (procAddr[31:2] == hamd_pkg::CONTIG_CFGD[31:2]);
    end
  end

endmodule // hamd_pci_addr

// File: hamd_decoder.sv
// Processor-side address decoder of the host bridge
// Operation
// - Reset selects legacy map until software switches
// - Legacy 0x8080_0000 window: direct configuration cycles
// - Legacy 0xC000_0000-0xFEFF_FFFF: PCI memory
// - Legacy system memory, ISA I/O, PCI I/O ranges
// - Legacy read at 0xBFFF_FFF0: interrupt acknowledge
// - Contiguous mode address translation and config ports
// - Discontiguous mode address translation and config ports
// - Direct config: one address bit per device select
// - Config address/data ports follow PCI mechanism
// - 0xFF00_0000-0xFF7F_FFFF: 64-bit large flash bank
// - Boot flash at 0xFFF0_0000, replicated, byte wide
// - System I/O at 0xFFE0_0000, replicated
// - Software may select the alternate map
// - Alternate: memory up to programmed top, else reserved
// - Alternate PCI memory 256M aligned, ISA memory
// - Alternate ISA I/O and PCI I/O ranges
// - Alternate 2M window: configuration address port
// - Alternate 1M window: configuration data port
// - Alternate interrupt ack; writes error if enabled
// - Cleared hole flag ignores 0xA_0000-0xB_FFFF
// - Reset also restores legacy PCI-master view
`timescale 1ns/1ps
module hamd_decoder #(
  parameter int IDSEL_COUNT = hamd_pkg::IDSEL_COUNT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cfgWrite,
  input wire logic cfgMapAlt,
  input wire logic cfgDiscontig,
  input wire logic cfgHoleFlag,
  input wire logic cfgTeaEnable,
  input wire logic [31:0] cfgMemTop,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  output logic mapAlt,
  output logic masterMapAlt,
  output logic discontigMode,
  output logic legacy_hole_decode_flag,
  output logic teaEnable,
  output logic [31:0] memTop,
  output logic cfgError,
  output logic ackValid,
  output hamd_pkg::hamd_target_t ackTarget,
  output logic [31:0] ackPciAddr,
  output logic [1:0] ackWidth,
  output logic [IDSEL_COUNT-1:0] ackIdsel,
  output logic transfer_error_ack_n
);

  // Device selects must stay below the window bit of the direct range
  if (IDSEL_COUNT < 1 || IDSEL_COUNT > 21 - hamd_pkg::IDSEL_FIRST_BIT + 1)
  begin : g_idsel_check
    $error("IDSEL_COUNT does not fit the direct configuration window");
  end

  hamd_pkg::hamd_map_t map_q;
  logic discontig_q;
  logic hole_q;
  logic tea_q;
  logic [31:0] memTop_q;
  logic cfgError_q;

  hamd_pkg::hamd_target_t target_d;
  logic error_d;
  logic [31:0] pciAddr_d;
  logic [1:0] width_d;
  logic [IDSEL_COUNT-1:0] idsel_d;
  logic [31:0] pciIoAddr;
  logic cfgAddrHit;
  logic cfgDataHit;

  function automatic logic inRange(
    input logic [31:0] a,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // Alternate PCI memory base must be 256M aligned
  function automatic logic aligned256(input logic [31:0] a);
    aligned256 = ((a & hamd_pkg::ALIGN_256M_MASK) == 32'h0000_0000);
  endfunction

  // Legacy hole, ignored only while its flag is cleared
  function automatic logic inHole(input logic [31:0] a, input logic flag);
    inHole = !flag && inRange(a, hamd_pkg::HOLE_LO, hamd_pkg::HOLE_HI);
  endfunction

  // Map select: legacy after every hard reset until software switches
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      map_q <= hamd_pkg::MAP_LEGACY;
    end
    else if (cfgWrite)
    begin
      map_q <= hamd_pkg::hamd_map_t'(cfgMapAlt);
    end
  end

  // Mode and enable bits, restored to their defaults on hard reset
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      discontig_q <= 1'b0;
      hole_q <= 1'b1;
      tea_q <= 1'b0;
    end
    else if (cfgWrite)
    begin
      discontig_q <= cfgDiscontig;
      hole_q <= cfgHoleFlag;
      tea_q <= cfgTeaEnable;
    end
  end

  // Highest system memory address of the alternate map
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memTop_q <= hamd_pkg::MEMTOP_RESET;
    end
    else if (cfgWrite)
    begin
      memTop_q <= cfgMemTop;
    end
  end

  // Flags a configuration write whose memory top collides with PCI memory
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfgError_q <= 1'b0;
    end
    else if (cfgWrite)
    begin
      cfgError_q <= cfgMapAlt && (cfgMemTop >= hamd_pkg::ALT_PCIMEM_LO
        || !aligned256(hamd_pkg::ALT_PCIMEM_LO));
    end
  end

  hamd_pci_addr u_pci_addr (
    .procAddr(reqAddr),
    .discontig(discontig_q),
    .pciIoAddr(pciIoAddr),
    .cfgAddrHit(cfgAddrHit),
    .cfgDataHit(cfgDataHit)
  );

  // Direct configuration device selects, one address bit each
  genvar gi;
  generate
    for (gi = 0; gi < IDSEL_COUNT; gi++)
    begin : g_idsel
      assign idsel_d[gi] = (target_d == hamd_pkg::TGT_CFG_DIRECT)
        && reqAddr[hamd_pkg::IDSEL_FIRST_BIT + gi];
    end
  endgenerate

  always_comb
  begin
    target_d = hamd_pkg::TGT_NONE;
    error_d = 1'b0;
    pciAddr_d = reqAddr;
    width_d = hamd_pkg::WIDTH_WORD;
    if (inRange(reqAddr, hamd_pkg::FLASH_BIG_LO, hamd_pkg::FLASH_BIG_HI))
    begin
      target_d = hamd_pkg::TGT_FLASH_BIG;
      width_d = hamd_pkg::WIDTH_DWORD;
    end
    else if (reqAddr[31:24] == 8'hFF)
    begin
      // Upper 8M: odd megabytes boot flash, even ones system I/O
      if (reqAddr[hamd_pkg::MB_BIT])
      begin
        target_d = hamd_pkg::TGT_FLASH_BOOT;
        width_d = hamd_pkg::WIDTH_BYTE;
      end
      else
      begin
        target_d = hamd_pkg::TGT_SYSIO;
      end
    end
    else if (map_q == hamd_pkg::MAP_LEGACY)
    begin
      if (!reqAddr[31])
      begin
        if (inHole(reqAddr, hole_q))
        begin
          target_d = hamd_pkg::TGT_NONE;
        end
        else
        begin
          target_d = hamd_pkg::TGT_SYSMEM;
        end
      end
      else if (reqAddr < hamd_pkg::LEG_CFGD_LO)
      begin
        pciAddr_d = pciIoAddr;
        if (cfgAddrHit)
        begin
          target_d = hamd_pkg::TGT_CFG_ADDR;
        end
        else if (cfgDataHit)
        begin
          target_d = hamd_pkg::TGT_CFG_DATA;
        end
        else
        begin
          target_d = hamd_pkg::TGT_ISA_IO;
        end
      end
      else if (reqAddr < hamd_pkg::LEG_PCIIO_LO)
      begin
        target_d = hamd_pkg::TGT_CFG_DIRECT;
      end
      else if (inRange(reqAddr, hamd_pkg::LEG_PCIIO_LO, hamd_pkg::LEG_PCIIO_HI))
      begin
        target_d = hamd_pkg::TGT_PCI_IO;
        pciAddr_d = pciIoAddr;
      end
      else if (reqAddr >= hamd_pkg::LEG_INTACK_LO && reqAddr < hamd_pkg::LEG_PCIMEM_LO)
      begin
        if (!reqWrite)
        begin
          target_d = hamd_pkg::TGT_INTACK;
        end
        else
        begin
          error_d = 1'b1;
        end
      end
      else if (inRange(reqAddr, hamd_pkg::LEG_PCIMEM_LO, hamd_pkg::LEG_PCIMEM_HI))
      begin
        target_d = hamd_pkg::TGT_PCI_MEM;
      end
      else
      begin
        error_d = 1'b1;
      end
    end
    else
    begin
      if (!reqAddr[31])
      begin
        if (reqAddr > memTop_q)
        begin
          error_d = 1'b1;
        end
        else if (inHole(reqAddr, hole_q))
        begin
          target_d = hamd_pkg::TGT_NONE;
        end
        else
        begin
          target_d = hamd_pkg::TGT_SYSMEM;
        end
      end
      else if (inRange(reqAddr, hamd_pkg::ALT_PCIMEM_LO, hamd_pkg::ALT_PCIMEM_HI))
      begin
        target_d = hamd_pkg::TGT_PCI_MEM;
      end
      else if (reqAddr < hamd_pkg::ALT_ISAIO_LO)
      begin
        target_d = hamd_pkg::TGT_ISA_MEM;
      end
      else if (reqAddr < hamd_pkg::ALT_PCIIO_LO)
      begin
        target_d = hamd_pkg::TGT_ISA_IO;
        pciAddr_d = {8'h00, reqAddr[23:0]};
      end
      else if (reqAddr < hamd_pkg::ALT_CFGA_LO)
      begin
        target_d = hamd_pkg::TGT_PCI_IO;
        pciAddr_d = {8'h00, reqAddr[23:0]};
      end
      else if (reqAddr < hamd_pkg::ALT_CFGD_LO)
      begin
        target_d = hamd_pkg::TGT_CFG_ADDR;
      end
      else if (reqAddr < hamd_pkg::ALT_INTACK_LO)
      begin
        target_d = hamd_pkg::TGT_CFG_DATA;
      end
      else if (!reqWrite)
      begin
        target_d = hamd_pkg::TGT_INTACK;
      end
      else
      begin
        error_d = tea_q;
      end
    end
  end

  // One registered answer per accepted request
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ackValid <= 1'b0;
      ackTarget <= hamd_pkg::TGT_NONE;
      ackPciAddr <= 32'h0000_0000;
      ackWidth <= hamd_pkg::WIDTH_WORD;
      ackIdsel <= '0;
    end
    else
    begin
      ackValid <= reqValid;
      ackTarget <= reqValid ? target_d : hamd_pkg::TGT_NONE;
      ackPciAddr <= reqValid ? pciAddr_d : 32'h0000_0000;
      ackWidth <= reqValid ? width_d : hamd_pkg::WIDTH_WORD;
      ackIdsel <= reqValid ? idsel_d : '0;
    end
  end

  // Error acknowledge, low for one cycle with the answer it belongs to
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transfer_error_ack_n <= 1'b1;
    end
    else
    begin
      transfer_error_ack_n <= !(reqValid && error_d);
    end
  end

  assign mapAlt = (map_q == hamd_pkg::MAP_ALT);
  assign masterMapAlt = (map_q == hamd_pkg::MAP_ALT);
  assign discontigMode = discontig_q;
  assign legacy_hole_decode_flag = hole_q;
  assign teaEnable = tea_q;
  assign memTop = memTop_q;
  assign cfgError = cfgError_q;

endmodule // hamd_decoder

// File: hamd_decoder_checker.sv
// Port assertions for the host address map decoder
`timescale 1ns/1ps
module hamd_decoder_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cfgWrite,
  input wire logic cfgMapAlt,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  input wire logic mapAlt,
  input wire logic masterMapAlt,
  input wire logic teaEnable,
  input wire logic ackValid,
  input wire hamd_pkg::hamd_target_t ackTarget,
  input wire logic [1:0] ackWidth,
  input wire logic [7:0] ackIdsel,
  input wire logic transfer_error_ack_n
);
  logic [31:0] reqAddr_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clock)
    reqAddr_q <= reqAddr;
  a_map_load: assert property (cfgWrite |=> mapAlt == $past(cfgMapAlt))
    else $error("map select not loaded");
  a_map_hold: assert property (!cfgWrite |=> $stable(mapAlt))
    else $error("map changed without a write");
  a_master_view: assert property (masterMapAlt == mapAlt)
    else $error("master view map differs");
  a_err_with_ack: assert property (!transfer_error_ack_n |-> ackValid)
    else $error("error outside an answer");
  a_pcimem_leg: assert property (reqValid && !mapAlt && reqAddr >= 32'hC000_0000
    && reqAddr <= 32'hFEFF_FFFF |=> ackTarget == hamd_pkg::TGT_PCI_MEM)
    else $error("legacy PCI memory missed");
  a_flash_big: assert property (reqValid && reqAddr[31:23] == 9'h1FE
    |=> ackTarget == hamd_pkg::TGT_FLASH_BIG && ackWidth == 2'h3)
    else $error("large flash missed");
  a_boot_byte: assert property (reqValid && reqAddr[31:23] == 9'h1FF && reqAddr[20]
    |=> ackTarget == hamd_pkg::TGT_FLASH_BOOT && ackWidth == 2'h0)
    else $error("boot flash missed");
  a_sysio_repl: assert property (reqValid && reqAddr[31:23] == 9'h1FF && !reqAddr[20]
    |=> ackTarget == hamd_pkg::TGT_SYSIO)
    else $error("system port missed");
  a_idsel_bit: assert property (reqValid && !mapAlt && reqAddr[31:23] == 9'h101
    |=> ackTarget == hamd_pkg::TGT_CFG_DIRECT && ackIdsel == reqAddr_q[18:11])
    else $error("device select wrong");
  a_intack_wr: assert property (reqValid && mapAlt && reqWrite && reqAddr[31:20] == 12'hFEF
    |=> transfer_error_ack_n == !$past(teaEnable))
    else $error("acknowledge write error wrong");
  cover property (reqValid && mapAlt);
  cover property (!transfer_error_ack_n);
  cover property (ackTarget == hamd_pkg::TGT_CFG_DIRECT);
endmodule // hamd_decoder_checker

bind hamd_decoder hamd_decoder_checker chk (.clock(clock), .arst_n(arst_n),
  .cfgWrite(cfgWrite), .cfgMapAlt(cfgMapAlt), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqAddr(reqAddr), .mapAlt(mapAlt), .masterMapAlt(masterMapAlt), .teaEnable(teaEnable),
  .ackValid(ackValid), .ackTarget(ackTarget), .ackWidth(ackWidth), .ackIdsel(ackIdsel),
  .transfer_error_ack_n(transfer_error_ack_n));

// File: hamd_cpu_model.sv
// Processor core model issuing decoder accesses
`timescale 1ns/1ps
module hamd_cpu_model (
  input wire logic clock,
  output logic reqValid,
  output logic reqWrite,
  output logic [31:0] reqAddr
);
  initial
  begin
    reqValid = 1'h0;
    reqWrite = 1'h0;
    reqAddr = 32'h0;
  end
  task automatic access(input logic [31:0] a, input logic w);
    @(posedge clock);
    #1;
    reqValid = 1'h1;
    reqWrite = w;
    reqAddr = a;
    @(posedge clock);
    #1;
    reqValid = 1'h0;
    // Released lines carry no stale value
    reqWrite = ~w;
    reqAddr = ~a;
  endtask
endmodule // hamd_cpu_model

// File: hamd_decoder_test.sv
// Self-checking testbench of the host address map decoder
`timescale 1ns/1ps
module hamd_decoder_test;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic cfgWrite = 1'h0;
  logic cfgMapAlt = 1'h0, cfgDiscontig = 1'h0, cfgHoleFlag = 1'h1, cfgTeaEnable = 1'h0;
  logic [31:0] cfgMemTop = 32'h7FFF_FFFF;
  logic reqValid, reqWrite, mapAlt, masterMapAlt, discontigMode, legacy_hole_decode_flag;
  logic teaEnable, cfgError, ackValid, transfer_error_ack_n;
  logic [31:0] reqAddr, memTop, ackPciAddr;
  logic [1:0] ackWidth;
  logic [7:0] ackIdsel;
  hamd_pkg::hamd_target_t ackTarget;
  int fails = 0;
  int comparisons = 0;
  always #25 clock = ~clock;
  hamd_cpu_model cpu (.clock(clock), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr));
  hamd_decoder dut (.clock(clock), .arst_n(arst_n), .cfgWrite(cfgWrite),
    .cfgMapAlt(cfgMapAlt), .cfgDiscontig(cfgDiscontig), .cfgHoleFlag(cfgHoleFlag),
    .cfgTeaEnable(cfgTeaEnable), .cfgMemTop(cfgMemTop), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .mapAlt(mapAlt), .masterMapAlt(masterMapAlt),
    .discontigMode(discontigMode), .legacy_hole_decode_flag(legacy_hole_decode_flag),
    .teaEnable(teaEnable), .memTop(memTop), .cfgError(cfgError), .ackValid(ackValid),
    .ackTarget(ackTarget), .ackPciAddr(ackPciAddr), .ackWidth(ackWidth),
    .ackIdsel(ackIdsel), .transfer_error_ack_n(transfer_error_ack_n));
  task automatic stop_test();
    $display("Comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic rst();
    #1;
    arst_n = 1'h0;
    repeat (2) @(posedge clock);
    #1;
    arst_n = 1'h1;
    chk({mapAlt, masterMapAlt, discontigMode, legacy_hole_decode_flag, teaEnable, ackValid,
      transfer_error_ack_n, cfgError}, 8'h12);
    chk(memTop, 32'h7FFF_FFFF);
    chk(ackTarget, hamd_pkg::TGT_NONE);
  endtask
  task automatic cfg(input logic alt, dis, hole, tea, input logic [31:0] top);
    @(posedge clock);
    #1;
    {cfgMapAlt, cfgDiscontig, cfgHoleFlag, cfgTeaEnable} = {alt, dis, hole, tea};
    cfgMemTop = top;
    cfgWrite = 1'h1;
    @(posedge clock);
    #1;
    cfgWrite = 1'h0;
    chk({mapAlt, discontigMode, legacy_hole_decode_flag, teaEnable},
      {alt, dis, hole, tea});
    chk(memTop, top);
  endtask
  task automatic acc(input logic [31:0] a, input logic w, input hamd_pkg::hamd_target_t t,
    input logic e);
    cpu.access(a, w);
    chk(ackValid, 1'h1);
    chk(ackTarget, t);
    chk(transfer_error_ack_n, e);
  endtask
  task automatic flash();
    acc(32'hFF00_0000, 1'h0, hamd_pkg::TGT_FLASH_BIG, 1'h1);
    acc(32'hFF7F_FFF8, 1'h1, hamd_pkg::TGT_FLASH_BIG, 1'h1);
    chk(ackWidth, 2'h3);
    for (int i = 0; i < 8; i++)
    begin
      acc({12'hFF8 + 12'(i), 20'h0}, 1'h0, hamd_pkg::hamd_target_t'(i[0] ?
        hamd_pkg::TGT_FLASH_BOOT : hamd_pkg::TGT_SYSIO), 1'h1);
      chk(ackWidth, i[0] ? 2'h0 : 2'h2);
    end
  endtask
  initial
  begin
    rst();
    acc(32'h0000_1000, 1'h1, hamd_pkg::TGT_SYSMEM, 1'h1);
    acc(32'h000A_0000, 1'h0, hamd_pkg::TGT_SYSMEM, 1'h1);
    acc(32'h8000_0CF8, 1'h1, hamd_pkg::TGT_CFG_ADDR, 1'h1);
    chk(ackPciAddr, 32'h0000_0CF8);
    acc(32'h8000_0CFF, 1'h0, hamd_pkg::TGT_CFG_DATA, 1'h1);
    acc(32'h8000_1234, 1'h0, hamd_pkg::TGT_ISA_IO, 1'h1);
    chk(ackPciAddr, 32'h0000_1234);
    acc(32'h8080_0800, 1'h0, hamd_pkg::TGT_CFG_DIRECT, 1'h1);
    chk(ackIdsel, 8'h01);
    acc(32'h8084_0000, 1'h1, hamd_pkg::TGT_CFG_DIRECT, 1'h1);
    chk(ackIdsel, 8'h80);
    acc(32'h8100_0000, 1'h0, hamd_pkg::TGT_PCI_IO, 1'h1);
    acc(32'hBF7F_FFFC, 1'h0, hamd_pkg::TGT_PCI_IO, 1'h1);
    acc(32'hBF80_0000, 1'h0, hamd_pkg::TGT_NONE, 1'h0);
    acc(32'hBFFF_FFF0, 1'h0, hamd_pkg::TGT_INTACK, 1'h1);
    acc(32'hBFFF_FFF4, 1'h1, hamd_pkg::TGT_NONE, 1'h0);
    acc(32'hC000_0000, 1'h1, hamd_pkg::TGT_PCI_MEM, 1'h1);
    acc(32'hFEFF_FFFC, 1'h0, hamd_pkg::TGT_PCI_MEM, 1'h1);
    flash();
    cfg(1'h0, 1'h1, 1'h1, 1'h0, 32'h7FFF_FFFF);
    acc(32'h8006_7018, 1'h1, hamd_pkg::TGT_CFG_ADDR, 1'h1);
    chk(ackPciAddr, 32'h0000_0CF8);
    acc(32'h8006_701D, 1'h0, hamd_pkg::TGT_CFG_DATA, 1'h1);
    acc(32'h8001_2345, 1'h0, hamd_pkg::TGT_ISA_IO, 1'h1);
    chk(ackPciAddr, 32'h0000_0245);
    cfg(1'h1, 1'h0, 1'h0, 1'h1, 32'h01FF_FFFF);
    chk({masterMapAlt, cfgError}, 2'h2);
    acc(32'h01FF_FFFC, 1'h0, hamd_pkg::TGT_SYSMEM, 1'h1);
    acc(32'h0200_0000, 1'h0, hamd_pkg::TGT_NONE, 1'h0);
    acc(32'h000A_0000, 1'h0, hamd_pkg::TGT_NONE, 1'h1);
    acc(32'h8000_0000, 1'h0, hamd_pkg::TGT_PCI_MEM, 1'h1);
    acc(32'hFCFF_FFFC, 1'h0, hamd_pkg::TGT_PCI_MEM, 1'h1);
    acc(32'hFD00_0000, 1'h0, hamd_pkg::TGT_ISA_MEM, 1'h1);
    acc(32'hFE00_0000, 1'h0, hamd_pkg::TGT_ISA_IO, 1'h1);
    acc(32'hFE80_0000, 1'h0, hamd_pkg::TGT_PCI_IO, 1'h1);
    acc(32'hFEBF_FFFC, 1'h0, hamd_pkg::TGT_PCI_IO, 1'h1);
    acc(32'hFEC0_0000, 1'h1, hamd_pkg::TGT_CFG_ADDR, 1'h1);
    acc(32'hFEDF_FFFC, 1'h0, hamd_pkg::TGT_CFG_ADDR, 1'h1);
    acc(32'hFEE0_0000, 1'h1, hamd_pkg::TGT_CFG_DATA, 1'h1);
    acc(32'hFEF0_0000, 1'h0, hamd_pkg::TGT_INTACK, 1'h1);
    cpu.access(32'hFEF0_0000, 1'h1);
    chk(transfer_error_ack_n, 1'h0);
    flash();
    cfg(1'h1, 1'h0, 1'h0, 1'h0, 32'h01FF_FFFF);
    cpu.access(32'hFEF0_0004, 1'h1);
    chk(transfer_error_ack_n, 1'h1);
    cfg(1'h1, 1'h0, 1'h0, 1'h0, 32'h8000_0000);
    chk(cfgError, 1'h1);
    rst();
    acc(32'hC000_0000, 1'h0, hamd_pkg::TGT_PCI_MEM, 1'h1);
    stop_test();
  end
  initial
  begin
    #50000;
    fails++;
    stop_test();
  end
endmodule // hamd_decoder_test
